// ---- afc_regs.sv ----
// Alarm flag, identity and soft reset / calibration control registers
//
// Functional notes
// - Input two loss flag latches, holds.
// - Input one loss flag latches until cleared.
// - Reference loss flag latches until cleared.
// - Input two offset flag latches until cleared.
// - Input one offset flag latches until cleared.
// - Lock loss flag latches until cleared.
// - Interrupt when unmasked flag and pin enabled.
// - Writing zero clears a flag.
// - Read-only 12-bit identity plus revision.
// - Control bit 7 resets flags, calibration and settings, outputs off.
// - Control bit 6 starts calibration, self-clears.
// - Calibration done shown by lock alarm low.
// - Settings take effect only when a calibration starts.
// - Live lock status: 0 locked, 1 unlocked.
`timescale 1ns/1ps
`default_nettype none
module afc_regs #(
	parameter int SRST_CYCLES = afc_pkg::SOFT_RST_CYCLES,
	parameter int CFG_W = 32,
	parameter logic [11:0] PART_ID = afc_pkg::PART_ID_DEF,
	parameter logic [3:0] REV_ID = afc_pkg::REV_ID_DEF
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic in2_signal_loss_live,
	input wire logic in1_signal_loss_live,
	input wire logic refin_signal_loss_live,
	input wire logic in2_freq_offset_live,
	input wire logic in1_freq_offset_live,
	input wire logic lock_loss_live,
	input wire logic [afc_pkg::ALM_N-1:0] alarm_mask,
	input wire logic int_pin_en,
	input wire logic [CFG_W-1:0] cfg_pending,
	output logic [CFG_W-1:0] cfg_active,
	output logic cal_start,
	output logic lock_loss_alarm,
	output logic int_out,
	output logic out_en
);
	import afc_pkg::*;

	// ---------------------------------------------------------------
	// Synchronise live alarms from detector domains
	// ---------------------------------------------------------------
	logic [ALM_N-1:0] live_raw;
	logic [ALM_N-1:0] live_m_q;
	logic [ALM_N-1:0] live_s_q;
	assign live_raw = {in2_freq_offset_live, in1_freq_offset_live, lock_loss_live,
		in2_signal_loss_live, in1_signal_loss_live, refin_signal_loss_live};

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			live_m_q <= FLAGS_RST;
			live_s_q <= FLAGS_RST;
		end else if (ce) begin
			live_m_q <= live_raw;
			live_s_q <= live_m_q;
		end
	end

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	logic srst_act_q;
	logic wr_ok;
	logic srst_wr;
	logic cal_wr;
	assign wr_ok = reg_wr && !srst_act_q;
	assign srst_wr = wr_ok && reg_addr == OFF_CTRL && reg_wdata[BIT_SOFT_RST];
	// Soft reset wins over a calibration start in the same write
	assign cal_wr = wr_ok && reg_addr == OFF_CTRL && reg_wdata[BIT_SELF_CAL] && !reg_wdata[BIT_SOFT_RST];

	// Zero written to a flag bit clears it; one leaves it
	function automatic logic [ALM_N-1:0] clr_mask(input logic [7:0] a, input logic [7:0] d);
		logic [ALM_N-1:0] m;
		m = '0;
		if (a == OFF_LOS_FLG) begin
			m[A_REFIN_LOS] = !d[BIT_REFIN_LOS];
			m[A_IN1_LOS] = !d[BIT_IN1_LOS];
			m[A_IN2_LOS] = !d[BIT_IN2_LOS];
		end
		if (a == OFF_FOS_FLG) begin
			m[A_LOCK] = !d[BIT_LOCK];
			m[A_IN1_FOS] = !d[BIT_IN1_FOS];
			m[A_IN2_FOS] = !d[BIT_IN2_FOS];
		end
		return m;
	endfunction

	// ---------------------------------------------------------------
	// Sticky flags
	// ---------------------------------------------------------------
	afc_alm_if alm();
	logic [ALM_N-1:0] flags;
	assign alm.live = live_s_q;
	assign alm.clr = wr_ok ? clr_mask(reg_addr, reg_wdata) : '0;
	assign flags = alm.flags;

	afc_sticky u_sticky (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.srst(srst_act_q),
		.alm(alm)
	);

	// ---------------------------------------------------------------
	// Soft reset counter
	// ---------------------------------------------------------------
	logic [31:0] srst_cnt_q;
	logic [31:0] srst_cnt_d;
	logic srst_act_d;
	always_comb begin
		srst_act_d = srst_act_q;
		srst_cnt_d = srst_cnt_q;
		if (srst_wr) begin
			srst_act_d = 1'b1;
			srst_cnt_d = 32'(SRST_CYCLES - 1);
		end else if (srst_act_q) begin
			if (srst_cnt_q == 32'h0000_0000) begin
				srst_act_d = 1'b0;
			end else begin
				srst_cnt_d = srst_cnt_q - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			srst_act_q <= 1'b0;
			srst_cnt_q <= 32'h0000_0000;
		end else if (ce) begin
			srst_act_q <= srst_act_d;
			srst_cnt_q <= srst_cnt_d;
		end
	end

	// ---------------------------------------------------------------
	// Calibration sequencer
	// ---------------------------------------------------------------
	afc_cal_t cal_q;
	afc_cal_t cal_d;
	logic [CFG_W-1:0] cfg_q;
	logic [CFG_W-1:0] cfg_d;
	always_comb begin
		cal_d = cal_q;
		cfg_d = cfg_q;
		if (srst_act_q) begin
			cal_d = CAL_IDLE;
			cfg_d = '0;
		end else if (cal_wr) begin
			cal_d = CAL_START;
		end else begin
			unique case (cal_q)
				CAL_IDLE: begin
					cal_d = CAL_IDLE;
				end
				CAL_START: begin
					cfg_d = cfg_pending;
					cal_d = CAL_WAIT;
				end
				CAL_WAIT: begin
					if (!live_s_q[A_LOCK]) begin
						cal_d = CAL_IDLE;
					end
				end
				default: begin
					cal_d = CAL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cal_q <= CAL_IDLE;
			cfg_q <= '0;
		end else if (ce) begin
			cal_q <= cal_d;
			cfg_q <= cfg_d;
		end
	end

	// ---------------------------------------------------------------
	// Read data and alarm output
	// ---------------------------------------------------------------
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic alarm_q;
	logic alarm_d;
	always_comb begin
		rdata_d = rdata_q;
		alarm_d = !srst_act_q && !srst_wr && (live_s_q[A_LOCK] || cal_q != CAL_IDLE);
		if (reg_rd && !srst_act_q) begin
			rdata_d = 8'h00;
			unique case (reg_addr)
				OFF_LIVE_LOS: rdata_d[2:0] = live_s_q[A_IN2_LOS:A_REFIN_LOS];
				OFF_LIVE_FOS: rdata_d[2:0] = {live_s_q[A_IN2_FOS:A_IN1_FOS], live_s_q[A_LOCK]};
				OFF_LOS_FLG: rdata_d[2:0] = flags[A_IN2_LOS:A_REFIN_LOS];
				OFF_FOS_FLG: rdata_d[3:1] = {flags[A_IN2_FOS:A_IN1_FOS], flags[A_LOCK]};
				OFF_ID_HI: rdata_d = PART_ID[11:4];
				OFF_ID_LO: rdata_d = {PART_ID[3:0], REV_ID};
				OFF_CTRL: rdata_d[BIT_SELF_CAL] = cal_q != CAL_IDLE;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= RDATA_RST;
			alarm_q <= 1'b0;
		end else if (ce) begin
			rdata_q <= rdata_d;
			alarm_q <= alarm_d;
		end
	end

	// Outputs, disabled while soft reset runs, except reg_rdata, which holds its last value
	assign reg_rdata = rdata_q;
	assign cfg_active = cfg_q;
	assign cal_start = cal_q == CAL_START;
	assign lock_loss_alarm = alarm_q;
	assign out_en = !srst_act_q;
	assign int_out = out_en && int_pin_en && |(flags & ~alarm_mask);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_in2_los_latch: assert property (ce && !srst_act_q && live_s_q[A_IN2_LOS] |=> flags[A_IN2_LOS])
		else $error("input two loss flag not latched");
	a_in1_los_hold: assert property (ce && !srst_act_q && flags[A_IN1_LOS] && !alm.clr[A_IN1_LOS]
		|=> flags[A_IN1_LOS])
		else $error("input one loss flag lost");
	a_refin_los_latch: assert property (ce && !srst_act_q && live_s_q[A_REFIN_LOS] |=> flags[A_REFIN_LOS])
		else $error("reference loss flag not latched");
	a_fos_latch: assert property (ce && !srst_act_q && live_s_q[A_IN2_FOS] |=> flags[A_IN2_FOS])
		else $error("input two offset flag not latched");
	a_in1_fos_latch: assert property (ce && !srst_act_q && live_s_q[A_IN1_FOS] |=> flags[A_IN1_FOS])
		else $error("input one offset flag not latched");
	a_lock_flag_latch: assert property (ce && !srst_act_q && live_s_q[A_LOCK] |=> flags[A_LOCK])
		else $error("lock loss flag not latched");
	a_flag_zero_clear: assert property (ce && wr_ok && reg_addr == OFF_LOS_FLG && !reg_wdata[BIT_IN1_LOS]
		&& !live_s_q[A_IN1_LOS] |=> !flags[A_IN1_LOS])
		else $error("zero write did not clear flag");
	a_int_gate: assert property (flags[A_LOCK] && !alarm_mask[A_LOCK] && int_pin_en && out_en |-> int_out)
		else $error("interrupt missing for unmasked flag");
	a_id_read: assert property (ce && reg_rd && !srst_act_q && reg_addr == OFF_ID_LO
		|=> reg_rdata == {PART_ID[3:0], REV_ID})
		else $error("identity read wrong");
	a_soft_rst_out: assert property (ce && srst_wr |=> !out_en && !int_out && !lock_loss_alarm && !cal_start)
		else $error("outputs not disabled by soft reset");
	a_cal_start: assert property (ce && cal_wr && !srst_wr |=> cal_start)
		else $error("calibration start missing");
	a_cal_single: assert property (ce && cal_start && !cal_wr |=> !cal_start)
		else $error("calibration start not a single pulse");
	a_cfg_apply: assert property (ce && cal_start && !srst_act_q && !cal_wr |=> cfg_active == $past(cfg_pending))
		else $error("settings not applied at calibration");
endmodule
`default_nettype wire

// ---- afc_pkg.sv ----
// Constants and types shared by the alarm flag and control register bank
package afc_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_LIVE_LOS = 8'h81;
	localparam logic [7:0] OFF_LIVE_FOS = 8'h82;
	localparam logic [7:0] OFF_LOS_FLG = 8'h83;
	localparam logic [7:0] OFF_FOS_FLG = 8'h84;
	localparam logic [7:0] OFF_ID_HI = 8'h86;
	localparam logic [7:0] OFF_ID_LO = 8'h87;
	localparam logic [7:0] OFF_CTRL = 8'h88;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_REFIN_LOS = 0;
	localparam int BIT_IN1_LOS = 1;
	localparam int BIT_IN2_LOS = 2;
	localparam int BIT_LOCK = 1;
	localparam int BIT_IN1_FOS = 2;
	localparam int BIT_IN2_FOS = 3;
	localparam int BIT_SOFT_RST = 7;
	localparam int BIT_SELF_CAL = 6;
	// Alarm vector order inside the bank
	localparam int ALM_N = 6;
	localparam int A_REFIN_LOS = 0;
	localparam int A_IN1_LOS = 1;
	localparam int A_IN2_LOS = 2;
	localparam int A_LOCK = 3;
	localparam int A_IN1_FOS = 4;
	localparam int A_IN2_FOS = 5;
	// ---------------------------------------------------------------
	// Reset values and timing
	// ---------------------------------------------------------------
	localparam logic [ALM_N-1:0] FLAGS_RST = 6'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam int CLK_MHZ = 250;
	localparam int SOFT_RST_TIME_MS = 10;
	localparam int SOFT_RST_CYCLES = SOFT_RST_TIME_MS * CLK_MHZ * 1000;
	localparam logic [11:0] PART_ID_DEF = 12'h05A3; // Arbitrary value
	localparam logic [3:0] REV_ID_DEF = 4'h7; // Arbitrary value
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_START = 2'b01,
		CAL_WAIT = 2'b10
	} afc_cal_t;
endpackage

// ---- afc_alm_if.sv ----
// Interface between register bank and its sticky flag module
`timescale 1ns/1ps
`default_nettype none
interface afc_alm_if;
	import afc_pkg::*;
	logic [ALM_N-1:0] live;
	logic [ALM_N-1:0] clr;
	logic [ALM_N-1:0] flags;
	modport bank (output live, output clr, input flags);
	modport sticky (input live, input clr, output flags);
endinterface
`default_nettype wire

// ---- afc_sticky.sv ----
// Sticky alarm flags: set by live alarms, cleared by zero writes
`timescale 1ns/1ps
`default_nettype none
module afc_sticky (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic srst,
	afc_alm_if.sticky alm
);
	import afc_pkg::*;
	logic [afc_pkg::ALM_N-1:0] flags_q;
	logic [afc_pkg::ALM_N-1:0] flags_d;

	// ---------------------------------------------------------------
	// Flag update, set wins over clear
	// ---------------------------------------------------------------
	always_comb begin
		flags_d = flags_q;
		if (srst) begin
			flags_d = FLAGS_RST;
		end else begin
			flags_d = alm.live | (flags_q & ~alm.clr);
		end
	end

	// Registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= FLAGS_RST;
		end else if (ce) begin
			flags_q <= flags_d;
		end
	end

	assign alm.flags = flags_q;
endmodule
`default_nettype wire

// ---- afc_host_model.sv ----
// Host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module afc_host_model #(
	parameter int SRST_WAIT = 16
) (
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata
);
	// Idle bus from time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// One write, held across the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d; // Stale data not left on the bus
	endtask
	// One read, data taken once it has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	// Keep off the port while the soft reset runs
	task automatic quiet();
		repeat (SRST_WAIT + 2) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the alarm flag and control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import afc_pkg::*;
	localparam int SRST = 16;
	localparam logic [11:0] PID = 12'h03C9; // Arbitrary value
	localparam logic [3:0] RID = 4'h4; // Arbitrary value
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic [ALM_N-1:0] live = '0;
	logic [ALM_N-1:0] alarm_mask = '0;
	logic int_pin_en = 1'b0;
	logic [31:0] cfg_pending = 32'h0000_0000;
	logic [31:0] cfg_active;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic cal_start;
	logic lock_loss_alarm;
	logic int_out;
	logic out_en;
	logic [7:0] d;
	logic [ALM_N-1:0] m;
	logic e;
	int mismatches = 0;
	int cmp_count = 0;
	afc_host_model #(.SRST_WAIT(SRST)) i_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
	afc_regs #(.SRST_CYCLES(SRST), .PART_ID(PID), .REV_ID(RID)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .in2_signal_loss_live(live[A_IN2_LOS]), .in1_signal_loss_live(live[A_IN1_LOS]),
		.refin_signal_loss_live(live[A_REFIN_LOS]), .in2_freq_offset_live(live[A_IN2_FOS]),
		.in1_freq_offset_live(live[A_IN1_FOS]), .lock_loss_live(live[A_LOCK]), .alarm_mask(alarm_mask),
		.int_pin_en(int_pin_en), .cfg_pending(cfg_pending), .cfg_active(cfg_active), .cal_start(cal_start),
		.lock_loss_alarm(lock_loss_alarm), .int_out(int_out), .out_en(out_en));
	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	// Flag register holding each alarm
	function automatic logic [7:0] flag_off(input int i);
		return (i == A_LOCK || i >= A_IN1_FOS) ? OFF_FOS_FLG : OFF_LOS_FLG;
	endfunction
	// Flag bit of each alarm inside its register
	function automatic logic [7:0] flag_val(input int i);
		case (i)
			A_LOCK: return 8'h02;
			A_IN1_FOS: return 8'h04;
			A_IN2_FOS: return 8'h08;
			default: return 8'h01 << i;
		endcase
	endfunction
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// -------------------------------------------------------------
	// Clock, watchdog and tests
	// -------------------------------------------------------------
	always #2 clk_sys = ~clk_sys;
	// Cut a hang short
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		finish_test();
	end
	// Main sequence
	initial begin
		void'($urandom(32'hfd681c8d));
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		i_host.rd(OFF_ID_HI, d);
		check(d, PID[11:4]);
		i_host.wr(OFF_ID_LO, 8'hFF);
		i_host.rd(OFF_ID_LO, d);
		check(d, {PID[3:0], RID});
		i_host.rd(8'h85, d);
		check(d, 8'h00);
		i_host.wr(OFF_LOS_FLG, 8'hF8);
		i_host.rd(OFF_LOS_FLG, d);
		check(d, 8'h00);
		// Each alarm: latch, interrupt, keep on one, re-set, clear on zero
		for (int i = 0; i < ALM_N; i++) begin
			live[i] <= 1'b1;
			repeat (5) @(posedge clk_sys);
			live[i] <= 1'b0;
			repeat (5) @(posedge clk_sys);
			i_host.rd(flag_off(i), d);
			check(d, flag_val(i));
			m = 6'($urandom);
			e = 1'($urandom);
			if (i == 0) begin
				m = '0;
				e = 1'b1;
			end
			alarm_mask <= m;
			int_pin_en <= e;
			@(posedge clk_sys);
			#1;
			check(int_out, e & ~m[i]);
			i_host.wr(flag_off(i), flag_val(i));
			alarm_mask <= '0;
			int_pin_en <= 1'b1;
			i_host.rd(flag_off(i), d);
			check(d, flag_val(i));
			live[i] <= 1'b1;
			repeat (5) @(posedge clk_sys);
			i_host.wr(flag_off(i), 8'h00);
			i_host.rd(flag_off(i), d);
			check(d, flag_val(i));
			live[i] <= 1'b0;
			repeat (5) @(posedge clk_sys);
			i_host.wr(flag_off(i), 8'h00);
			i_host.rd(flag_off(i), d);
			check(d, 8'h00);
			check(int_out, 1'b0);
		end
		// Calibration applies pending settings and ends on lock
		live[A_LOCK] <= 1'b1;
		cfg_pending <= $urandom;
		repeat (4) @(posedge clk_sys);
		check(cfg_active, 32'h0000_0000);
		i_host.wr(OFF_CTRL, 8'h40);
		#1;
		check(cal_start, 1'b1);
		check(lock_loss_alarm, 1'b1);
		@(posedge clk_sys);
		#1;
		check(cal_start, 1'b0);
		check(cfg_active, cfg_pending);
		i_host.rd(OFF_CTRL, d);
		check(d, 8'h40);
		i_host.rd(OFF_LIVE_FOS, d);
		check(d, 8'h01);
		live[A_LOCK] <= 1'b0;
		repeat (6) @(posedge clk_sys);
		check(lock_loss_alarm, 1'b0);
		i_host.rd(OFF_CTRL, d);
		check(d, 8'h00);
		// Clear the lock flag left by calibration
		i_host.wr(OFF_FOS_FLG, 8'h00);
		@(posedge clk_sys);
		check(int_out, 1'b0);
		// Clock enable low freezes the synchroniser and flags
		ce <= 1'b0;
		live[A_REFIN_LOS] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check(int_out, 1'b0);
		ce <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check(int_out, 1'b1);
		i_host.rd(OFF_LIVE_LOS, d);
		check(d, 8'h01);
		live[A_REFIN_LOS] <= 1'b0;
		repeat (3) @(posedge clk_sys);
		i_host.wr(OFF_LOS_FLG, 8'h00);
		i_host.rd(OFF_LOS_FLG, d);
		check(d, 8'h00);
		// Soft reset clears flags and disables outputs
		live[A_IN2_FOS] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		live[A_IN2_FOS] <= 1'b0;
		check(int_out, 1'b1);
		i_host.wr(OFF_CTRL, 8'h80);
		#1;
		check(out_en, 1'b0);
		check(int_out, 1'b0);
		i_host.quiet();
		check(out_en, 1'b1);
		i_host.rd(OFF_FOS_FLG, d);
		check(d, 8'h00);
		i_host.rd(OFF_CTRL, d);
		check(d, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
